// *** rtl/ciu_pkg.sv ***
`default_nettype none
package ciu_pkg;
    // Priority levels on a 0..16 scale; five bits carry level 16.
    localparam logic [4:0] LVL_NMI      = 5'h10;
    localparam logic [4:0] LVL_UBRK     = 5'h0F;
    localparam logic [4:0] LVL_PROG_MAX = 5'h0F;
    localparam logic [3:0] MASK_NMI     = 4'hF;
    localparam logic [3:0] MASK_RESET   = 4'hF;
    // Status word field position of the interrupt mask level.
    localparam int         MASK_LSB     = 4;
    localparam logic [31:0] STATUS_RESET = 32'h000000F0;
    localparam logic [31:0] VBASE_RESET  = 32'h00000000;
    // Stack step in bytes and vector table entry size as a left shift.
    localparam logic [31:0] STACK_STEP  = 32'h00000004;
    localparam int          VEC_SHIFT   = 2;
    // Vector numbers of the fixed instruction exceptions and sources.
    localparam logic [7:0] VEC_ILLEGAL  = 8'h04;
    localparam logic [7:0] VEC_SLOT     = 8'h06;
    localparam logic [7:0] VEC_ADDR_ERR = 8'h09;
    localparam logic [7:0] VEC_NMI      = 8'h0B;
    localparam logic [7:0] VEC_UBRK     = 8'h0C;
    // Exception kinds; accepted in the order slot, illegal, trap, address, interrupt.
    typedef enum logic [2:0] {
        CIU_EX_NONE, CIU_EX_ILLEGAL, CIU_EX_SLOT, CIU_EX_TRAP, CIU_EX_ADDR, CIU_EX_INTR
    } ciu_kind_t;
endpackage
`default_nettype wire

// *** rtl/ciu_exception_unit.sv ***
// Functional notes
// - Priority levels span zero to sixteen
// - Non-maskable is level sixteen, never masked
// - User break fixed at level fifteen
// - Programmable sources limited to levels 0-15
// - Arbiter presents the highest pending request
// - Maskable accepted only above mask level
// - Push status then PC, load mask
// - Non-maskable loads mask with fifteen
// - Fetch vector entry then jump there
// - Every source has its own vector
// - Trap pushes status, next address, vectors
// - Exception jump has no delay slot
// - Illegal slot raised at slot decode
// - PC-rewriting ops illegal in delay slot
// - Illegal slot pushes the branch target
// - Undefined code pushes its own address
// - No interrupt or address error in slot
// - After control load/store: interrupts held
// - Refused sources stay pending until accepted
// - Vector address is base plus number times four
// - Each push predecrements stack by four
`default_nettype none
module ciu_exception_unit (
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Decode boundary information from the pipeline.
    input  wire logic        dec_valid,
    input  wire logic [31:0] dec_pc,
    input  wire logic [31:0] dec_next_pc,
    input  wire logic        dec_undefined,
    input  wire logic        dec_rewrites_pc,
    input  wire logic        dec_delayed_branch,
    input  wire logic [31:0] dec_branch_target,
    input  wire logic        dec_ctrl_loadstore,
    input  wire logic        dec_software_trap_op,
    input  wire logic [7:0]  dec_trap_vector,
    input  wire logic        addr_error,
    // Interrupt arbiter request.
    input  wire logic        irq_valid,
    input  wire logic [4:0]  irq_level,
    input  wire logic [7:0]  irq_vector,
    // Architectural registers seen by the unit.
    input  wire logic [31:0] status_word,
    input  wire logic [31:0] vector_base,
    input  wire logic [31:0] stack_ptr,
    // Memory port for stacking and vector fetch.
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    output logic             mem_req,
    output logic             mem_we,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    // Results handed back to the core.
    output logic             exc_busy,
    output logic             exc_done,
    output logic [31:0]      new_pc,
    output logic [31:0]      new_sp,
    output logic [31:0]      new_status_word,
    output logic             irq_ack
);
    ////////////////////////////////////////////////////////////////////////////
    // Reset release.
    logic       rst_q1;
    logic       rst_n;

    // Reset is asserted at once and released after two clean edges.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acceptance decision at a decode boundary.
    typedef enum logic [2:0] {CIU_IDLE, CIU_PUSH_SR, CIU_PUSH_PC, CIU_FETCH, CIU_DONE} ciu_state_t;
    ciu_state_t state;

    logic       in_slot;
    logic       after_ctrl;
    logic       addr_pend;
    logic       irq_ok;
    logic       addr_ok;
    logic       take_irq;
    ciu_pkg::ciu_kind_t next_kind;
    logic [31:0] next_push_pc;
    logic [7:0]  next_vec;
    logic [3:0]  next_mask;
    logic [3:0]  cur_mask;

    assign cur_mask = status_word[ciu_pkg::MASK_LSB +: 4];

    assign addr_ok = !in_slot;
    assign irq_ok  = irq_valid && !in_slot && !after_ctrl &&
                     ((irq_level == ciu_pkg::LVL_NMI) || (irq_level > {1'b0, cur_mask}));
    assign take_irq = (next_kind == ciu_pkg::CIU_EX_INTR);

    // One source per decision; instruction faults of the decoded op win.
    always_comb begin
        next_kind    = ciu_pkg::CIU_EX_NONE;
        next_push_pc = dec_pc;
        next_vec     = ciu_pkg::VEC_ILLEGAL;
        next_mask    = cur_mask;
        // Decodes offered outside idle, the done cycle included, are ignored.
        if (dec_valid && state == CIU_IDLE) begin
            if (in_slot && (dec_undefined || dec_rewrites_pc || dec_software_trap_op)) begin
                next_kind    = ciu_pkg::CIU_EX_SLOT;
                next_vec     = ciu_pkg::VEC_SLOT;
                next_push_pc = dec_branch_target;
            end else if (dec_undefined) begin
                next_kind    = ciu_pkg::CIU_EX_ILLEGAL;
                next_vec     = ciu_pkg::VEC_ILLEGAL;
                next_push_pc = dec_pc;
            end else if (dec_software_trap_op) begin
                next_kind    = ciu_pkg::CIU_EX_TRAP;
                next_vec     = dec_trap_vector;
                next_push_pc = dec_next_pc;
            end else if ((addr_pend || addr_error) && addr_ok) begin
                next_kind    = ciu_pkg::CIU_EX_ADDR;
                next_vec     = ciu_pkg::VEC_ADDR_ERR;
                next_push_pc = dec_pc;
            end else if (irq_ok) begin
                next_kind    = ciu_pkg::CIU_EX_INTR;
                next_vec     = irq_vector;
                next_push_pc = dec_pc;
                next_mask    = (irq_level == ciu_pkg::LVL_NMI) ? ciu_pkg::MASK_NMI : irq_level[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode context tracking.
    // delay slot flag
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            in_slot    <= 1'b0;
            after_ctrl <= 1'b0;
        end else if (dec_valid && state == CIU_IDLE) begin
            in_slot    <= dec_delayed_branch && (next_kind == ciu_pkg::CIU_EX_NONE);
            after_ctrl <= dec_ctrl_loadstore && (next_kind == ciu_pkg::CIU_EX_NONE);
        end else if (state == CIU_DONE) begin
            in_slot    <= 1'b0;
            after_ctrl <= 1'b0;
        end
    end

    // held address error
    // A fresh error in the accepting cycle re-arms a held one, so set wins over clear.
    // A fresh error that is itself the one taken is consumed, to avoid a double entry.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addr_pend <= 1'b0;
        end else if (addr_error && (addr_pend || next_kind != ciu_pkg::CIU_EX_ADDR)) begin
            addr_pend <= 1'b1;
        end else if (next_kind == ciu_pkg::CIU_EX_ADDR) begin
            addr_pend <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stacking and vector fetch sequence.
    logic [31:0] saved_pc;
    logic [31:0] saved_sr;
    logic [31:0] sp;
    logic [7:0]  vec;
    logic [3:0]  mask_new;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= CIU_IDLE;
        end else begin
            case (state)
                CIU_IDLE: begin
                    if (next_kind != ciu_pkg::CIU_EX_NONE) begin
                        state <= CIU_PUSH_SR;
                    end
                end
                CIU_PUSH_SR: begin
                    if (mem_ack) begin
                        state <= CIU_PUSH_PC;
                    end
                end
                CIU_PUSH_PC: begin
                    if (mem_ack) begin
                        state <= CIU_FETCH;
                    end
                end
                CIU_FETCH: begin
                    if (mem_ack) begin
                        state <= CIU_DONE;
                    end
                end
                // One quiet cycle lets the core load the new context before decode resumes.
                CIU_DONE: state <= CIU_IDLE;
                default:  state <= CIU_IDLE;
            endcase
        end
    end

    // Capture of the context of the accepted exception.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            saved_pc <= 32'h00000000;
            saved_sr <= ciu_pkg::STATUS_RESET;
            sp       <= 32'h00000000;
            vec      <= 8'h00;
            mask_new <= ciu_pkg::MASK_RESET;
        end else if (state == CIU_IDLE && next_kind != ciu_pkg::CIU_EX_NONE) begin
            saved_pc <= next_push_pc;
            saved_sr <= status_word;
            sp       <= stack_ptr;
            vec      <= next_vec;
            mask_new <= next_mask;
        end else if ((state == CIU_PUSH_SR || state == CIU_PUSH_PC) && mem_ack) begin
            sp <= sp - ciu_pkg::STACK_STEP;
        end
    end

    // Memory port: each push writes at sp minus four, then the fetch reads.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= 32'h00000000;
            mem_wdata <= 32'h00000000;
        end else begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            if (state == CIU_IDLE && next_kind != ciu_pkg::CIU_EX_NONE) begin
                mem_req   <= 1'b1;
                mem_we    <= 1'b1;
                mem_addr  <= stack_ptr - ciu_pkg::STACK_STEP;
                mem_wdata <= status_word;
            end else if (state == CIU_PUSH_SR && !mem_ack) begin
                mem_req <= 1'b1;
                mem_we  <= 1'b1;
            end else if (state == CIU_PUSH_SR) begin
                mem_req   <= 1'b1;
                mem_we    <= 1'b1;
                mem_addr  <= sp - (ciu_pkg::STACK_STEP << 1);
                mem_wdata <= saved_pc;
            end else if (state == CIU_PUSH_PC && !mem_ack) begin
                mem_req <= 1'b1;
                mem_we  <= 1'b1;
            end else if (state == CIU_PUSH_PC) begin
                mem_req   <= 1'b1;
                mem_addr  <= vector_base + {22'h0, vec, 2'h0};
                mem_wdata <= 32'h00000000;
            end else if (state == CIU_FETCH && !mem_ack) begin
                mem_req <= 1'b1;
            end
        end
    end

    // Results: PC jumps straight to the fetched entry with no slot.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            exc_busy        <= 1'b0;
            exc_done        <= 1'b0;
            new_pc          <= 32'h00000000;
            new_sp          <= 32'h00000000;
            new_status_word <= ciu_pkg::STATUS_RESET;
            irq_ack         <= 1'b0;
        end else begin
            exc_done <= 1'b0;
            irq_ack  <= take_irq;
            if (state == CIU_IDLE && next_kind != ciu_pkg::CIU_EX_NONE) begin
                exc_busy <= 1'b1;
            end else if (state == CIU_FETCH && mem_ack) begin
                exc_busy        <= 1'b0;
                exc_done        <= 1'b1;
                new_pc          <= mem_rdata;
                new_sp          <= sp;
                new_status_word <= saved_sr;
                if (vec == ciu_pkg::VEC_NMI || mask_new != saved_sr[ciu_pkg::MASK_LSB +: 4]) begin
                    new_status_word[ciu_pkg::MASK_LSB +: 4] <= mask_new;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** verification/ciu_exc_checker.sv ***
`default_nettype none
module ciu_exc_checker (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        dec_valid,
    input wire logic        dec_undefined,
    input wire logic        dec_rewrites_pc,
    input wire logic        dec_delayed_branch,
    input wire logic        dec_software_trap_op,
    input wire logic [4:0]  irq_level,
    input wire logic [31:0] status_word,
    input wire logic [31:0] stack_ptr,
    input wire logic        mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic        exc_busy,
    input wire logic        exc_done,
    input wire logic [31:0] new_pc,
    input wire logic        irq_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic take;
    logic slot_next;
    // A decode only counts while the unit is idle; busy and done cycles are stalls.
    assign take = dec_valid && !exc_busy && !exc_done;
    // The decode after a delayed branch that raised nothing is its delay slot.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            slot_next <= 1'b0;
        end else if (exc_busy) begin
            slot_next <= 1'b0;
        end else if (take) begin
            slot_next <= dec_delayed_branch;
        end
    end
    property p_trap; take && dec_software_trap_op |=> mem_req && mem_we && mem_addr == stack_ptr - 32'h4
        && mem_wdata == $past(status_word); endproperty
    a_trap: assert property (p_trap) else $error("trap did not push status first");
    property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
    a_hold: assert property (p_hold) else $error("request dropped before ack");
    property p_push2; mem_req && mem_we && mem_ack && mem_addr == stack_ptr - 32'h4
        |=> mem_req && mem_we && mem_addr == stack_ptr - 32'h8; endproperty
    a_push2: assert property (p_push2) else $error("second push missing");
    property p_fetch; mem_req && !mem_we && mem_ack |=> exc_done && new_pc == $past(mem_rdata); endproperty
    a_fetch: assert property (p_fetch) else $error("jump not to fetched vector");
    property p_slot; take && slot_next && !(dec_undefined || dec_rewrites_pc || dec_software_trap_op)
        |=> !mem_req; endproperty
    a_slot: assert property (p_slot) else $error("exception taken in delay slot");
    property p_mask; irq_ack |-> $past(irq_level) == 5'h10
        || $past(irq_level) > {1'b0, $past(status_word[7:4])}; endproperty
    a_mask: assert property (p_mask) else $error("interrupt taken at or below mask");
    property p_iack; irq_ack |-> mem_req && mem_we && mem_addr == stack_ptr - 32'h4; endproperty
    a_iack: assert property (p_iack) else $error("interrupt without status push");
    property p_bound; mem_req && !mem_we |-> ##[1:40] exc_done; endproperty
    a_bound: assert property (p_bound) else $error("vector fetch never completed");
endmodule
`default_nettype wire

// *** verification/ciu_arb_model.sv ***
`default_nettype none
module ciu_arb_model (
    input  wire logic        mclk,
    input  wire logic        irq_ack,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output var  logic        irq_valid,
    output var  logic [4:0]  irq_level,
    output var  logic [7:0]  irq_vector,
    output var  logic        mem_ack,
    output var  logic [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    int          dly = 0;
    int          cnt = 0;
    int          nw = 0;
    logic [31:0] wa [2];
    logic [31:0] wd [2];
    initial {irq_valid, irq_level, irq_vector, mem_ack, mem_rdata} = '0;
    task automatic raise(input logic [4:0] lvl, input logic [7:0] vec);
        if (!irq_valid || lvl > irq_level) begin
            irq_level = lvl;
            irq_vector = vec;
        end
        irq_valid = 1'b1;
    endtask
    always @(posedge mclk) begin
        if (irq_ack) irq_valid <= 1'b0;
    end
    // Memory answers after dly cycles; read data churns when not answered.
    always @(posedge mclk) begin
        if (mem_ack || !mem_req) begin
            mem_ack <= 1'b0;
            cnt <= 0;
            mem_rdata <= ~mem_rdata;
        end else if (cnt < dly) begin
            cnt <= cnt + 1;
            mem_rdata <= ~mem_rdata;
        end else begin
            mem_ack <= 1'b1;
            mem_rdata <= ~mem_addr;
            if (mem_we && nw < 2) begin
                wa[nw] <= mem_addr;
                wd[nw] <= mem_wdata;
                nw <= nw + 1;
            end
        end
    end
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, nrst, dec_valid, dec_undefined, dec_rewrites_pc, dec_delayed_branch, g;
    logic        dec_ctrl_loadstore, dec_software_trap_op, addr_error, irq_valid, mem_ack, mem_req;
    logic        mem_we, exc_busy, exc_done, irq_ack;
    logic [4:0]  irq_level;
    logic [7:0]  dec_trap_vector, irq_vector;
    logic [31:0] dec_pc, dec_next_pc, dec_branch_target, status_word, vector_base, stack_ptr;
    logic [31:0] mem_rdata, mem_addr, mem_wdata, new_pc, new_sp, new_status_word;
    int          miscompares = 0;
    int          checked = 0;
    int          cycles = 0;
    ciu_exception_unit DUT (.mclk, .nrst, .dec_valid, .dec_pc, .dec_next_pc, .dec_undefined, .dec_rewrites_pc,
        .dec_delayed_branch, .dec_branch_target, .dec_ctrl_loadstore, .dec_software_trap_op, .dec_trap_vector,
        .addr_error, .irq_valid, .irq_level, .irq_vector, .status_word, .vector_base, .stack_ptr, .mem_ack,
        .mem_rdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .exc_busy, .exc_done, .new_pc, .new_sp,
        .new_status_word, .irq_ack);
    ciu_arb_model model (.mclk, .irq_ack, .mem_req, .mem_we, .mem_addr, .mem_wdata, .irq_valid, .irq_level,
        .irq_vector, .mem_ack, .mem_rdata);
    always #50 mclk = ~mclk;
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // A hung handshake ends the run here rather than stalling forever.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One decode boundary; f is undefined, rewrite, slot, ctrl, trap.
    task automatic run(input logic [4:0] f, output logic got);
        model.nw = 0;
        got = 1'b0;
        dec_valid = 1'b1;
        {dec_undefined, dec_rewrites_pc, dec_delayed_branch, dec_ctrl_loadstore, dec_software_trap_op} = f;
        @(posedge mclk);
        #1;
        dec_valid = 1'b0;
        {dec_undefined, dec_rewrites_pc, dec_delayed_branch, dec_ctrl_loadstore, dec_software_trap_op} = 5'h00;
        for (int i = 0; i < 30 && !got; i++) begin
            if (exc_done === 1'b1) got = 1'b1;
            else begin
                @(posedge mclk);
                #1;
            end
        end
        // The done cycle ignores decodes, so let it pass before the next one.
        @(posedge mclk);
        #1;
    endtask
    task automatic exp_exc(input logic got, input logic [31:0] pc, input logic [7:0] vec, input logic [3:0] m);
        chk({31'h0, got}, 32'h1);
        chk({31'h0, exc_busy}, 32'h0);
        chk(model.wa[0], stack_ptr - 32'h4);
        chk(model.wd[0], status_word);
        chk(model.wa[1], stack_ptr - 32'h8);
        chk(model.wd[1], pc);
        chk(new_pc, ~(vector_base + {22'h0, vec, 2'h0}));
        chk(new_sp, stack_ptr - 32'h8);
        chk({28'h0, new_status_word[7:4]}, {28'h0, m});
    endtask
    task automatic s_instr();
        logic [4:0] ops [3] = '{5'h10, 5'h0C, 5'h01};
        dec_trap_vector = 8'h21;
        run(5'h01, g);
        exp_exc(g, dec_next_pc, 8'h21, 4'h5);
        model.dly = 3;
        dec_trap_vector = 8'hFF;
        run(5'h01, g);
        exp_exc(g, dec_next_pc, 8'hFF, 4'h5);
        model.dly = 0;
        run(5'h10, g);
        exp_exc(g, dec_pc, ciu_pkg::VEC_ILLEGAL, 4'h5);
        // Each offending op sits in the slot of a plain delayed branch.
        foreach (ops[i]) begin
            run(5'h04, g);
            chk({31'h0, g}, 32'h0);
            run(ops[i], g);
            exp_exc(g, dec_branch_target, ciu_pkg::VEC_SLOT, 4'h5);
        end
    endtask
    task automatic s_irq();
        model.raise(5'h05, 8'h40);
        run(5'h00, g);
        chk({31'h0, g}, 32'h0);
        model.raise(5'h06, 8'h41);
        run(5'h00, g);
        exp_exc(g, dec_pc, 8'h41, 4'h6);
        status_word = 32'hF0;
        stack_ptr = 32'h3000;
        model.raise(5'h0F, 8'h0C);
        run(5'h00, g);
        chk({31'h0, g}, 32'h0);
        model.raise(5'h10, 8'h0B);
        run(5'h00, g);
        exp_exc(g, dec_pc, 8'h0B, 4'hF);
    endtask
    task automatic s_defer();
        status_word = 32'h00;
        run(5'h02, g);
        chk({31'h0, g}, 32'h0);
        model.raise(5'h04, 8'h44);
        run(5'h00, g);
        chk({31'h0, g}, 32'h0);
        // A mask of five parks the request while the delayed branch itself is decoded.
        status_word = 32'h50;
        run(5'h04, g);
        chk({31'h0, g}, 32'h0);
        status_word = 32'h00;
        addr_error = 1'b1;
        @(posedge mclk);
        #1;
        addr_error = 1'b0;
        run(5'h02, g);
        chk({31'h0, g}, 32'h0);
        run(5'h00, g);
        exp_exc(g, dec_pc, ciu_pkg::VEC_ADDR_ERR, 4'h0);
        run(5'h00, g);
        exp_exc(g, dec_pc, 8'h44, 4'h4);
    endtask
    initial begin
        {mclk, nrst, dec_valid, addr_error} = 4'h0;
        {dec_undefined, dec_rewrites_pc, dec_delayed_branch, dec_ctrl_loadstore, dec_software_trap_op} = 5'h00;
        dec_trap_vector = 8'h00;
        status_word = 32'h50;
        vector_base = 32'h1000;
        stack_ptr = 32'h2000;
        dec_pc = 32'h400;
        dec_next_pc = 32'h402;
        dec_branch_target = 32'h800;
        repeat (10) @(posedge mclk);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        s_instr();
        s_irq();
        s_defer();
        test_done();
    end
endmodule
bind ciu_exception_unit ciu_exc_checker mon (.mclk, .nrst, .dec_valid, .dec_undefined, .dec_rewrites_pc,
    .dec_delayed_branch, .dec_software_trap_op, .irq_level, .status_word, .stack_ptr, .mem_ack, .mem_rdata,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .exc_busy, .exc_done, .new_pc, .irq_ack);
`default_nettype wire
